// file: clk_rst_pkg.sv
/*
  Shared constants and types for the clock, reset and oscillation controller.
  Assumes a single 100 MHz sampling clock and an 8-bit register port.
*/
`default_nettype none
package clk_rst_pkg;

  // register port addresses
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CPU_MODE = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;

  // clock control register fields
  localparam int CC_SEL_LSB = 0;
  localparam int CC_SUB_EN = 2;
  localparam int CC_SUB_DRV_DIS = 5;
  localparam int CC_MAIN_DRV_DIS = 6;
  // cpu mode register field
  localparam int CM_MAIN_STOP = 5;

  // system clock source codes
  localparam logic [1:0] SRC_SYN = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_MAIN_DIV2 = 2'h2;
  localparam logic [1:0] SRC_SUB = 2'h3;

  // values after reset
  localparam logic [1:0] SEL_RESET = SRC_MAIN;
  localparam logic SUB_EN_RESET = 1'b0;
  localparam logic DRV_DIS_RESET = 1'b0;
  localparam logic MAIN_STOP_RESET = 1'b0;

  // reset vector bytes
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFB;

  // stabilization timers
  localparam logic [7:0] T1_LOAD = 8'h00FF;
  localparam logic [7:0] T2_LOAD = 8'h0001;
  // phi / 8 equals sixteen system clock edges
  localparam logic [3:0] PRESC_LAST = 4'h000F;

  // pin positions in the synchronised pin vector
  localparam int PIN_RESET = 0;
  localparam int PIN_BOOT = 1;
  localparam int PIN_MAIN = 2;
  localparam int PIN_SUB = 3;
  localparam int PIN_SYN = 4;
  localparam int PIN_COUNT = 5;
  localparam logic [4:0] PIN_RESET_VAL = 5'h0000;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_STAB,
    ST_VEC_HI,
    ST_VEC_LO,
    ST_VEC_DONE,
    ST_RUN,
    ST_WAIT,
    ST_STOP
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } bus_req_t;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
    logic main_half;
    logic [1:0] ctl_sel;
    logic [1:0] act_sel;
    logic skip;
    logic sub_en;
    logic sub_drv_dis;
    logic main_drv_dis;
    logic main_stop;
    mode_t mode;
    logic from_reset;
    logic phi;
    logic [3:0] presc;
    logic [7:0] t1;
    logic [7:0] t2;
    logic [15:0] vector;
    logic [15:0] vec_addr;
    logic vec_rd;
    logic cpu_start;
    logic [7:0] rdata;
  } ctl_state_t;

endpackage : clk_rst_pkg
`default_nettype wire

// file: clock_reset_oscillation_control.sv
/*
  Clock, reset and oscillation controller: reset release and vector fetch,
  four-way glitch-free system clock select, half-rate cpu clock, stop and
  wait modes, timer-based stabilization after stop.
  Assumes oscillator and reset pins are asynchronous to clk, which samples
  them at a rate well above the fastest source; vector memory answers a
  read in the next cycle; irq inputs are synchronous to clk.
*/
`default_nettype none

module clock_reset_oscillation_control (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // device pins
  input wire logic reset_pin_n,
  input wire logic boot_mode_pin,
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  input wire logic syn_clk_in,
  // oscillator control
  output logic main_osc_run,
  output logic main_amp_en,
  output logic sub_osc_run,
  output logic sub_amp_en,
  output logic sub_pins_gpio,
  // pin direction during reset
  output logic port_force_out,
  output logic port_force_in,
  // register port
  input wire clk_rst_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  // cpu core and interrupt logic
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic ext_irq,
  input wire logic any_irq,
  output logic cpu_clk,
  output logic cpu_reset,
  output logic cpu_start,
  output logic [15:0] reset_vector,
  // vector memory read
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_rdata
);

  clk_rst_pkg::ctl_state_t s;
  clk_rst_pkg::ctl_state_t next_s;

  logic [4:0] agree;
  logic [4:0] next_lvl;
  logic [4:0] rise;
  logic main_div2_rise;
  logic [3:0] src_edge;
  logic old_edge;
  logic sys_edge;
  logic phi_run;
  logic tick;
  logic t1_uf;
  logic t2_uf;
  logic in_reset;
  logic in_stop;

  // filtered pin levels: a change counts once the second and third stages agree
  always_comb begin
    agree = ~(s.s2 ^ s.s3);
    next_lvl = (agree & s.s3) | (~agree & s.lvl);
    rise = next_lvl & ~s.lvl;
  end

  // source edge events, indexed by source code
  always_comb begin
    main_div2_rise = rise[clk_rst_pkg::PIN_MAIN] & ~s.main_half;
    src_edge[clk_rst_pkg::SRC_SYN] = rise[clk_rst_pkg::PIN_SYN];
    src_edge[clk_rst_pkg::SRC_MAIN] = rise[clk_rst_pkg::PIN_MAIN];
    src_edge[clk_rst_pkg::SRC_MAIN_DIV2] = main_div2_rise;
    src_edge[clk_rst_pkg::SRC_SUB] = rise[clk_rst_pkg::PIN_SUB];
    old_edge = src_edge[s.act_sel];
    // first edge after a switch only realigns, it is not counted
    sys_edge = old_edge & ~s.skip;
  end

  always_comb begin
    in_reset = (s.mode == clk_rst_pkg::ST_RESET);
    in_stop = (s.mode == clk_rst_pkg::ST_STOP);
    phi_run = (s.mode == clk_rst_pkg::ST_RUN) ||
              (s.mode == clk_rst_pkg::ST_VEC_HI) ||
              (s.mode == clk_rst_pkg::ST_VEC_LO) ||
              (s.mode == clk_rst_pkg::ST_VEC_DONE);
    tick = sys_edge && (s.presc == clk_rst_pkg::PRESC_LAST);
    t1_uf = tick && (s.t1 == 8'h0000);
    t2_uf = t1_uf && (s.t2 == 8'h0000);
  end

  always_comb begin
    next_s = s;
    next_s.s1 = {syn_clk_in, sub_osc_in, main_osc_in, boot_mode_pin, reset_pin_n};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.lvl = next_lvl;
    next_s.vec_rd = 1'b0;
    next_s.cpu_start = 1'b0;

    if (rise[clk_rst_pkg::PIN_MAIN]) begin
      next_s.main_half = ~s.main_half;
    end

    // hand over to the new source only on an edge of the old one
    if (old_edge) begin
      if (s.ctl_sel != s.act_sel) begin
        next_s.act_sel = s.ctl_sel;
        next_s.skip = 1'b1;
      end else begin
        next_s.skip = 1'b0;
      end
    end

    // phi toggles on each system clock edge; halted it parks high
    if (sys_edge) begin
      if (phi_run) begin
        next_s.phi = ~s.phi;
      end else begin
        next_s.phi = 1'b1;
      end
    end else if (in_stop) begin
      // a stopped oscillator gives no edge, so park phi high at once
      next_s.phi = 1'b1;
    end

    // register writes
    if (bus.we) begin
      case (bus.addr)
        clk_rst_pkg::ADDR_CLK_CTRL: begin
          next_s.ctl_sel = bus.wdata[clk_rst_pkg::CC_SEL_LSB +: 2];
          next_s.sub_en = bus.wdata[clk_rst_pkg::CC_SUB_EN];
          next_s.sub_drv_dis = bus.wdata[clk_rst_pkg::CC_SUB_DRV_DIS];
          next_s.main_drv_dis = bus.wdata[clk_rst_pkg::CC_MAIN_DRV_DIS];
        end
        clk_rst_pkg::ADDR_CPU_MODE: begin
          next_s.main_stop = bus.wdata[clk_rst_pkg::CM_MAIN_STOP];
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the following cycle, unmapped reads zero
    next_s.rdata = 8'h0000;
    if (bus.re) begin
      case (bus.addr)
        clk_rst_pkg::ADDR_CLK_CTRL: begin
          next_s.rdata[clk_rst_pkg::CC_SEL_LSB +: 2] = s.ctl_sel;
          next_s.rdata[clk_rst_pkg::CC_SUB_EN] = s.sub_en;
          next_s.rdata[clk_rst_pkg::CC_SUB_DRV_DIS] = s.sub_drv_dis;
          next_s.rdata[clk_rst_pkg::CC_MAIN_DRV_DIS] = s.main_drv_dis;
        end
        clk_rst_pkg::ADDR_CPU_MODE: begin
          next_s.rdata[clk_rst_pkg::CM_MAIN_STOP] = s.main_stop;
        end
        clk_rst_pkg::ADDR_STATUS: begin
          next_s.rdata = {s.phi, s.skip, s.act_sel, 1'b0, s.mode};
        end
        default: begin
        end
      endcase
    end

    // stabilization timers: phi/8 prescaler, timer1 down count, timer2 on timer1
    if (s.mode == clk_rst_pkg::ST_STAB) begin
      if (sys_edge) begin
        next_s.presc = s.presc + 4'h0001;
      end
      if (tick) begin
        if (s.t1 == 8'h0000) begin
          next_s.t1 = clk_rst_pkg::T1_LOAD;
        end else begin
          next_s.t1 = s.t1 - 8'h0001;
        end
      end
      if (t1_uf && (s.t2 != 8'h0000)) begin
        next_s.t2 = s.t2 - 8'h0001;
      end
    end

    case (s.mode)
      clk_rst_pkg::ST_RESET: begin
        // release when the reset pin returns high
        if (s.lvl[clk_rst_pkg::PIN_RESET]) begin
          next_s.mode = clk_rst_pkg::ST_STAB;
          next_s.from_reset = 1'b1;
          next_s.presc = 4'h0000;
          next_s.t1 = clk_rst_pkg::T1_LOAD;
          next_s.t2 = clk_rst_pkg::T2_LOAD;
        end
      end
      clk_rst_pkg::ST_STAB: begin
        // phi held high until timer2 underflows
        if (t2_uf) begin
          if (s.from_reset) begin
            next_s.mode = clk_rst_pkg::ST_VEC_HI;
          end else begin
            next_s.mode = clk_rst_pkg::ST_RUN;
          end
        end
      end
      clk_rst_pkg::ST_VEC_HI: begin
        next_s.vec_rd = 1'b1;
        next_s.vec_addr = clk_rst_pkg::VEC_HI_ADDR;
        next_s.mode = clk_rst_pkg::ST_VEC_LO;
      end
      clk_rst_pkg::ST_VEC_LO: begin
        // memory answers in the cycle after each read strobe
        next_s.vec_rd = 1'b1;
        next_s.vec_addr = clk_rst_pkg::VEC_LO_ADDR;
        next_s.mode = clk_rst_pkg::ST_VEC_DONE;
      end
      clk_rst_pkg::ST_VEC_DONE: begin
        if (s.vec_rd) begin
          // high byte arrives while the low byte read stands
          next_s.vector[15:8] = vec_rdata;
        end else begin
          // low byte completes the start address
          next_s.vector[7:0] = vec_rdata;
          next_s.cpu_start = 1'b1;
          next_s.from_reset = 1'b0;
          next_s.mode = clk_rst_pkg::ST_RUN;
        end
      end
      clk_rst_pkg::ST_RUN: begin
        if (stop_instruction) begin
          // stop halts phi and both oscillators, timers loaded
          next_s.mode = clk_rst_pkg::ST_STOP;
          next_s.presc = 4'h0000;
          next_s.t1 = clk_rst_pkg::T1_LOAD;
          next_s.t2 = clk_rst_pkg::T2_LOAD;
        end else if (wait_instruction) begin
          next_s.mode = clk_rst_pkg::ST_WAIT;
        end
      end
      clk_rst_pkg::ST_WAIT: begin
        // any interrupt restarts phi with no delay
        if (any_irq || ext_irq) begin
          next_s.mode = clk_rst_pkg::ST_RUN;
        end
      end
      clk_rst_pkg::ST_STOP: begin
        // external interrupt restarts the oscillators, then stabilize
        if (ext_irq) begin
          next_s.mode = clk_rst_pkg::ST_STAB;
          next_s.from_reset = 1'b0;
          next_s.presc = 4'h0000;
          next_s.t1 = clk_rst_pkg::T1_LOAD;
          next_s.t2 = clk_rst_pkg::T2_LOAD;
        end
      end
      default: begin
        next_s.mode = clk_rst_pkg::ST_RESET;
      end
    endcase

    // pin reset overrides everything and restores register defaults
    if (!s.lvl[clk_rst_pkg::PIN_RESET]) begin
      next_s.mode = clk_rst_pkg::ST_RESET;
      // selector back to the main oscillator
      next_s.ctl_sel = clk_rst_pkg::SEL_RESET;
      // sub oscillator off, its pins general I/O
      next_s.sub_en = clk_rst_pkg::SUB_EN_RESET;
      next_s.sub_drv_dis = clk_rst_pkg::DRV_DIS_RESET;
      next_s.main_drv_dis = clk_rst_pkg::DRV_DIS_RESET;
      next_s.main_stop = clk_rst_pkg::MAIN_STOP_RESET;
      next_s.from_reset = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.s1 <= clk_rst_pkg::PIN_RESET_VAL;
      s.s2 <= clk_rst_pkg::PIN_RESET_VAL;
      s.s3 <= clk_rst_pkg::PIN_RESET_VAL;
      s.lvl <= clk_rst_pkg::PIN_RESET_VAL;
      s.main_half <= 1'b0;
      s.ctl_sel <= clk_rst_pkg::SEL_RESET;
      s.act_sel <= clk_rst_pkg::SEL_RESET;
      s.skip <= 1'b0;
      s.sub_en <= clk_rst_pkg::SUB_EN_RESET;
      s.sub_drv_dis <= clk_rst_pkg::DRV_DIS_RESET;
      s.main_drv_dis <= clk_rst_pkg::DRV_DIS_RESET;
      s.main_stop <= clk_rst_pkg::MAIN_STOP_RESET;
      s.mode <= clk_rst_pkg::ST_RESET;
      s.from_reset <= 1'b1;
      s.phi <= 1'b1;
      s.presc <= 4'h0000;
      s.t1 <= clk_rst_pkg::T1_LOAD;
      s.t2 <= clk_rst_pkg::T2_LOAD;
      s.vector <= 16'h0000;
      s.vec_addr <= 16'h0000;
      s.vec_rd <= 1'b0;
      s.cpu_start <= 1'b0;
      s.rdata <= 8'h0000;
    end else begin
      s <= next_s;
    end
  end

  // oscillator enables
  always_comb begin
    // main stop bit halts the main oscillator; stop halts both
    main_osc_run = ~s.main_stop & ~in_stop;
    // sub oscillator runs only once software enables it
    sub_osc_run = s.sub_en & ~in_stop & ~in_reset;
    // drive-disable bits turn off the amplifiers
    main_amp_en = main_osc_run & ~s.main_drv_dis;
    sub_amp_en = sub_osc_run & ~s.sub_drv_dis;
    sub_pins_gpio = ~s.sub_en;
    // pin directions while reset is held
    port_force_out = in_reset & s.lvl[clk_rst_pkg::PIN_BOOT];
    port_force_in = in_reset;
  end

  assign rdata = s.rdata;
  assign cpu_clk = s.phi;
  assign cpu_reset = in_reset | s.from_reset;
  assign cpu_start = s.cpu_start;
  assign reset_vector = s.vector;
  assign vec_rd = s.vec_rd;
  assign vec_addr = s.vec_addr;

endmodule : clock_reset_oscillation_control
`default_nettype wire

// file: clk_rst_monitor.sv
/* checker of the clock, reset and oscillation controller ports;
   bound to the top module, one domain clk with async reset rst_n */
`default_nettype none
module clk_rst_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire clk_rst_pkg::bus_req_t bus,
  input wire logic [7:0] rdata,
  // core side
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic any_irq,
  input wire logic cpu_clk,
  input wire logic cpu_reset,
  input wire logic cpu_start,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  // oscillators and pins
  input wire logic main_osc_run,
  input wire logic main_amp_en,
  input wire logic sub_osc_run,
  input wire logic sub_amp_en,
  input wire logic sub_pins_gpio,
  input wire logic port_force_out,
  input wire logic port_force_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // phi may be forced high at once in reset or with all oscillators off
  wire halted = cpu_reset || !(main_osc_run || sub_osc_run);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_force_out_in: assert property (port_force_out |-> port_force_in)
    else $error("pins driven outside reset");
  a_reset_defaults: assert property (port_force_in [*2] |-> sub_pins_gpio && main_osc_run)
    else $error("reset defaults wrong");
  a_sub_pins_free: assert property (sub_osc_run |-> !sub_pins_gpio)
    else $error("sub pins still general I/O");
  a_amp_follows: assert property ((main_amp_en -> main_osc_run) && (sub_amp_en -> sub_osc_run))
    else $error("amplifier on without oscillator");
  a_vec_order: assert property (vec_rd && vec_addr == clk_rst_pkg::VEC_HI_ADDR |=>
    vec_rd && vec_addr == clk_rst_pkg::VEC_LO_ADDR)
    else $error("vector low byte not fetched next");
  a_start_after_lo: assert property (vec_rd && vec_addr == clk_rst_pkg::VEC_LO_ADDR |->
    ##2 cpu_start && !cpu_reset)
    else $error("start not two cycles after low byte");
  a_start_pulse: assert property (cpu_start |=> !cpu_start && !vec_rd)
    else $error("start not a single pulse");
  a_stop_halts: assert property (stop_instruction && !cpu_reset |=>
    !main_osc_run && !sub_osc_run ##[0:8] cpu_clk [*8])
    else $error("stop did not halt");
  a_wait_parks: assert property (wait_instruction && !stop_instruction && !cpu_reset |=>
    $stable(main_osc_run) ##[0:12] cpu_clk [*8])
    else $error("wait did not park phi");
  a_rdata_idle: assert property (!$past(bus.re) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_phi_no_runt: assert property ($changed(cpu_clk) && !halted |=>
    ($stable(cpu_clk) || halted) [*3])
    else $error("short phi phase");

  c_vec_fetch: cover property (vec_rd ##1 vec_rd);
  c_wait_wake: cover property (wait_instruction ##[1:40] any_irq);
  c_stop: cover property (stop_instruction ##1 !main_osc_run);
  c_read: cover property (bus.re);
endmodule : clk_rst_monitor

bind clock_reset_oscillation_control clk_rst_monitor clk_rst_monitor_i (
  .clk, .rst_n, .bus, .rdata, .stop_instruction, .wait_instruction, .any_irq,
  .cpu_clk, .cpu_reset, .cpu_start, .vec_rd, .vec_addr, .main_osc_run, .main_amp_en,
  .sub_osc_run, .sub_amp_en, .sub_pins_gpio, .port_force_out, .port_force_in);
`default_nettype wire

// file: osc_partner.sv
/* partner model: reset source plus main, sub and synthesizer clocks;
   clk paces all waveforms, a stopped oscillator stands still */
`default_nettype none
module osc_partner (
  // pacing clock
  input wire logic clk,
  // oscillator enables
  input wire logic main_run,
  input wire logic sub_run,
  // device pins
  output logic reset_pin_n,
  output logic main_osc_in,
  output logic sub_osc_in,
  output logic syn_clk_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold = 300;
  int mc = 0;
  int sc = 0;
  int yc = 0;
  initial {reset_pin_n, main_osc_in, sub_osc_in, syn_clk_in} = 4'h0;
  always @(posedge clk) begin
    // pin low far beyond 20 phi periods
    hold <= (hold > 0) ? hold - 1 : 0;
    reset_pin_n <= (hold == 0);
    mc = main_run ? (mc + 1) % 2 : mc;
    sc = sub_run ? (sc + 1) % 3 : sc;
    yc = (yc + 1) % 5;
    if (main_run && mc == 0) main_osc_in <= ~main_osc_in;
    if (sub_run && sc == 0) sub_osc_in <= ~sub_osc_in;
    if (yc == 0) syn_clk_in <= ~syn_clk_in;
  end
endmodule : osc_partner
`default_nettype wire

// file: clock_reset_oscillation_control_bench.sv
/* self-checking bench of the clock controller with oscillator partner;
   a vector memory here answers one cycle after each read */
`default_nettype none
module clock_reset_oscillation_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, reset_pin_n, boot_mode_pin, main_osc_in, sub_osc_in, syn_clk_in;
  logic main_osc_run, main_amp_en, sub_osc_run, sub_amp_en, sub_pins_gpio;
  logic port_force_out, port_force_in, stop_instruction, wait_instruction;
  logic ext_irq, any_irq, cpu_clk, cpu_reset, cpu_start, vec_rd, seen, bad;
  logic [15:0] reset_vector, vec_addr;
  logic [7:0] rdata, vec_rdata, rv, d, vhi, vlo;
  logic [31:0] seed = 32'h0000_b602;
  clk_rst_pkg::bus_req_t bus;
  int failures = 0;
  int n_checks = 0;
  int n, k;

  clock_reset_oscillation_control clock_reset_oscillation_control_i (
    .clk, .rst_n, .reset_pin_n, .boot_mode_pin, .main_osc_in, .sub_osc_in, .syn_clk_in,
    .main_osc_run, .main_amp_en, .sub_osc_run, .sub_amp_en, .sub_pins_gpio,
    .port_force_out, .port_force_in, .bus, .rdata, .stop_instruction, .wait_instruction,
    .ext_irq, .any_irq, .cpu_clk, .cpu_reset, .cpu_start, .reset_vector, .vec_rd,
    .vec_addr, .vec_rdata);
  osc_partner osc_partner_i (.clk, .main_run(main_osc_run), .sub_run(sub_osc_run),
    .reset_pin_n, .main_osc_in, .sub_osc_in, .syn_clk_in);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // outside its valid cycle the data keeps changing
  always @(posedge clk)
    vec_rdata <= !vec_rd ? ~vec_rdata : vec_addr == clk_rst_pkg::VEC_HI_ADDR ? vhi : vlo;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // phi period in clk cycles: twice the partner's source period, four times the main period for main / 2
  function automatic int phi_per(logic [1:0] s);
    case (s)
      clk_rst_pkg::SRC_SYN: return 20;
      clk_rst_pkg::SRC_MAIN_DIV2: return 16;
      clk_rst_pkg::SRC_SUB: return 12;
      default: return 8;
    endcase
  endfunction : phi_per
  task automatic complete_run();
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic tmo();
    failures++;
    complete_run();
  endtask : tmo
  task automatic cmp16(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16
  task automatic cmp1(logic got, logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  task automatic xfer(logic we, logic [7:0] a, logic [7:0] wd);
    @(posedge clk);
    bus <= '{a, wd, we, !we};
    @(posedge clk);
    bus <= '0;
    #1 rv = rdata;
  endtask : xfer
  task automatic fall_in(int lim);
    for (k = 0; cpu_clk !== 1'h0 && k < lim; k++)
      @(posedge clk) #1;
    if (k >= lim) tmo();
  endtask : fall_in
  // cycles spanned by four phi periods
  task automatic phi_cycles();
    k = 0;
    n = 0;
    seen = 1'h1;
    while (k < 5 && n < 2000) begin
      @(posedge clk) #1;
      if (k > 0) n++;
      if (cpu_clk && !seen) k++;
      seen = cpu_clk;
    end
    if (n >= 2000) tmo();
  endtask : phi_cycles

  initial begin
    rst_n = 1'h0;
    bus = '0;
    boot_mode_pin = 1'h1;
    {stop_instruction, wait_instruction, ext_irq, any_irq} = 4'h0;
    vec_rdata = 8'h00;
    void'(rnd());
    {vhi, vlo} = seed[15:0];
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    #1 cmp1(port_force_in, 1'h1);
    cmp1(port_force_out, 1'h1);
    cmp1(sub_pins_gpio, 1'h1);
    cmp1(sub_osc_run, 1'h0);
    cmp1(main_osc_run, 1'h1);
    xfer(0, clk_rst_pkg::ADDR_CLK_CTRL, 0);
    cmp16({8'h00, rv}, 16'h0001);
    xfer(0, clk_rst_pkg::ADDR_STATUS, 0);
    cmp16({8'h00, rv & 8'hbf}, 16'h0090);
    @(posedge clk) boot_mode_pin <= 1'h0;
    repeat (6) @(posedge clk);
    #1 cmp1(port_force_out, 1'h0);
    cmp1(port_force_in, 1'h1);
    {seen, bad} = 2'h0;
    for (k = 0; k < 40000 && cpu_start !== 1'h1; k++) begin
      @(posedge clk) #1;
      seen |= vec_rd;
      bad |= !seen && cpu_clk !== 1'h1;
    end
    if (k >= 40000) tmo();
    cmp1(bad, 1'h0);
    cmp16(reset_vector, {vhi, vlo});
    cmp1(cpu_reset, 1'h0);
    xfer(0, 8'ha5, 0);
    cmp16({8'h00, rv}, 16'h0000);
    xfer(1, clk_rst_pkg::ADDR_CLK_CTRL, 8'h05);
    repeat (60) @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      void'(rnd());
      d = {1'h0, seed[1:0], 2'h0, 1'h1, s[1:0]};
      xfer(1, clk_rst_pkg::ADDR_CLK_CTRL, d);
      xfer(0, clk_rst_pkg::ADDR_CLK_CTRL, 0);
      cmp16({8'h00, rv & 8'h67}, {8'h00, d});
      cmp1(main_amp_en, !d[6]);
      cmp1(sub_amp_en, !d[5]);
      cmp1(sub_pins_gpio, 1'h0);
      repeat (60) @(posedge clk);
      phi_cycles();
      cmp16(16'(n), 16'(4 * phi_per(d[1:0])));
    end
    xfer(1, clk_rst_pkg::ADDR_CPU_MODE, 8'h20);
    cmp1(main_osc_run, 1'h0);
    phi_cycles();
    cmp16(16'(n), 16'(4 * 12));
    xfer(1, clk_rst_pkg::ADDR_CPU_MODE, 8'h00);
    repeat (60) @(posedge clk);
    xfer(1, clk_rst_pkg::ADDR_CLK_CTRL, 8'h05);
    repeat (60) @(posedge clk);
    wait_instruction <= 1'h1;
    @(posedge clk) wait_instruction <= 1'h0;
    repeat (20) @(posedge clk);
    #1 cmp1(cpu_clk, 1'h1);
    cmp1(main_osc_run, 1'h1);
    @(posedge clk) any_irq <= 1'h1;
    @(posedge clk) any_irq <= 1'h0;
    fall_in(40);
    cmp1(k < 12, 1'h1);
    @(posedge clk) stop_instruction <= 1'h1;
    @(posedge clk) stop_instruction <= 1'h0;
    #1 cmp1(main_osc_run, 1'h0);
    cmp1(sub_osc_run, 1'h0);
    repeat (100) @(posedge clk);
    #1 cmp1(cpu_clk, 1'h1);
    @(posedge clk) ext_irq <= 1'h1;
    @(posedge clk) ext_irq <= 1'h0;
    #1 cmp1(main_osc_run, 1'h1);
    fall_in(40000);
    // two timer1 rounds of 256 ticks, 16 main edges each, 4 clk apart
    cmp1(k > 32768 - 64 && k < 32768 + 128, 1'h1);
    phi_cycles();
    cmp16(16'(n), 16'(4 * 8));
    complete_run();
  end
endmodule : clock_reset_oscillation_control_bench
`default_nettype wire
